//--- design/ldad_dev.sv
// device end: configuration registers for gpio bank 3 output type,
// logical device activate and docking base, plus the runtime decode
// assumes host cycles on pclk and range hits from neighbouring logic
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - bank3 bit: 0 push-pull, 1 open-drain
// - bank3 type register resets 0xff on standby
// - activate register only at index 3ah
// - bit0 gates fast ir engine access
// - bit1 gates runtime register block decode
// - bit2 gates consumer ir controller access
// - bit3 gates docking switch register access
// - bits 4-7 read zero, ignore writes
// - activate register resets to zero
// - cleared bit removes device from decode
// - software sets valid base before bit3
// - dock base bytes at indices 3bh, 3ch
// - dock base anywhere in 16-bit space
// - software clears bit3 before base rewrite
// - dock decode compares all sixteen bits
// - high byte bits 15:8, low 7:0, reset zero
module ldad_dev
  import ldad_pkg::*;
#(
  parameter logic [15:0] CFG_PORT = CFG_PORT_DEFAULT,
  parameter int          NPINS    = 8
) (
  // clock and resets
  input  wire logic             pclk,
  input  wire logic             presetn,        // main power reset
  input  wire logic             sby_presetn,    // standby power reset
  // link to host
  ldad_link_if.dev              link,
  // range hits from the owners of the other base registers
  input  wire logic             fir_range_hit,
  input  wire logic             rt_range_hit,
  input  wire logic             cir_range_hit,
  // docking switch register
  input  wire logic [7:0]       dock_rdata,
  output logic                  dock_sel,       // one-cycle access pulse
  output logic                  dock_we,
  output logic [7:0]            dock_wdata,
  // runtime selects, one-cycle pulses
  output logic                  fir_sel,
  output logic                  rt_sel,
  output logic                  cir_sel,
  // decode enables and docking base for the rest of the chip
  output logic [ACT_BITS-1:0]   active,
  output logic [15:0]           dock_base,
  // gpio bank 3 pad drive
  input  wire logic [NPINS-1:0] gpio3_dir,      // 1 output
  input  wire logic [NPINS-1:0] gpio3_data,
  output logic [NPINS-1:0]      gpio3_pin_out,
  output logic [NPINS-1:0]      gpio3_pin_oe_n
);

  // configuration state
  logic [7:0]          cfg_index;
  logic [7:0]          next_cfg_index;
  logic [ACT_BITS-1:0] act;
  logic [ACT_BITS-1:0] next_act;
  logic [7:0]          base_hi;
  logic [7:0]          next_base_hi;
  logic [7:0]          base_lo;
  logic [7:0]          next_base_lo;
  logic [7:0]          otype;
  logic [7:0]          next_otype;

  // cycle answer state
  logic                ack;
  logic                next_ack;
  logic [7:0]          rdata;
  logic [7:0]          next_rdata;
  logic                claim;
  logic                next_claim;
  logic                dsel;
  logic                next_dsel;
  logic                dwe;
  logic                next_dwe;
  logic [7:0]          dwdata;
  logic [7:0]          next_dwdata;
  logic [2:0]          rsel;
  logic [2:0]          next_rsel;

  // decode terms
  logic                index_hit;
  logic                data_hit;
  logic                cfg_hit;
  logic                dock_hit;
  logic                fir_hit;
  logic                rt_hit;
  logic                cir_hit;
  logic [7:0]          cfg_rd;
  logic [15:0]         data_port;

  // the data port wraps to 0000h if the index port sits at ffffh, truncated to 16 bits
  assign data_port = 16'(CFG_PORT + CFG_DATA_OFFSET);

  // configuration ports only answer in configuration state
  assign index_hit = link.cfg_mode && (link.io_addr == CFG_PORT);
  assign data_hit  = link.cfg_mode && (link.io_addr == data_port);
  assign cfg_hit   = index_hit || data_hit;

  // runtime decode; config ports take precedence over any device range
  assign fir_hit  = act[ACT_FIR] && fir_range_hit && !cfg_hit;
  assign rt_hit   = act[ACT_RT] && rt_range_hit && !cfg_hit;
  assign cir_hit  = act[ACT_CIR] && cir_range_hit && !cfg_hit;
  // exact 16-bit compare, no address bit ignored
  assign dock_hit = act[ACT_DOCK] && !cfg_hit &&
                    (link.io_addr == {base_hi, base_lo});

  // read mux over the configuration register slice
  always_comb begin
    case (cfg_index)
      IDX_GPIO3_OTYPE: cfg_rd = otype;
      // upper bits are zero-padded, never stored
      IDX_ACTIVATE:    cfg_rd = {{(8-ACT_BITS){1'b0}}, act};
      IDX_DOCK_HI:     cfg_rd = base_hi;
      IDX_DOCK_LO:     cfg_rd = base_lo;
      default:         cfg_rd = FLOAT_DATA;
    endcase
  end

  // configuration register writes through the data port
  always_comb begin
    next_cfg_index = cfg_index;
    next_act       = act;
    next_base_hi   = base_hi;
    next_base_lo   = base_lo;
    next_otype     = otype;
    if (link.io_req && link.io_wr && index_hit) begin
      next_cfg_index = link.io_wdata;
    end
    if (link.io_req && link.io_wr && data_hit) begin
      case (cfg_index)
        IDX_GPIO3_OTYPE: next_otype = link.io_wdata;
        // only the four activate bits are kept
        IDX_ACTIVATE:    next_act = link.io_wdata[ACT_BITS-1:0];
        // base bytes are taken as written; the host is expected to have
        // cleared the dock enable first, decode follows the new value
        IDX_DOCK_HI:     next_base_hi = link.io_wdata;
        IDX_DOCK_LO:     next_base_lo = link.io_wdata;
        default:         next_act = act;
      endcase
    end
  end

  // main power domain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_index <= RST_INDEX;
      act       <= RST_ACTIVATE;
      base_hi   <= RST_DOCK_BYTE;
      base_lo   <= RST_DOCK_BYTE;
    end else begin
      cfg_index <= next_cfg_index;
      act       <= next_act;
      base_hi   <= next_base_hi;
      base_lo   <= next_base_lo;
    end
  end

  // standby domain: pad type survives a main power reset
  always_ff @(posedge pclk or negedge sby_presetn) begin
    if (!sby_presetn) begin
      otype <= RST_GPIO3_OTYPE;
    end else begin
      otype <= next_otype;
    end
  end

  // answer every cycle one clock after its request
  always_comb begin
    next_ack    = link.io_req;
    next_claim  = 1'b0;
    next_rdata  = FLOAT_DATA;
    next_dsel   = 1'b0;
    next_dwe    = 1'b0;
    next_dwdata = dwdata;
    next_rsel   = 3'b000;
    if (link.io_req) begin
      next_claim = cfg_hit || dock_hit || fir_hit || rt_hit || cir_hit;
      next_rsel  = {cir_hit, rt_hit, fir_hit};
      if (index_hit) begin
        next_rdata = cfg_index;
      end else if (data_hit) begin
        next_rdata = cfg_rd;
      end else if (dock_hit) begin
        next_rdata  = dock_rdata;
        next_dsel   = 1'b1;
        next_dwe    = link.io_wr;
        next_dwdata = link.io_wdata;
      end
    end
  end

  // answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack    <= 1'b0;
      claim  <= 1'b0;
      rdata  <= FLOAT_DATA;
      dsel   <= 1'b0;
      dwe    <= 1'b0;
      dwdata <= 8'h00;
      rsel   <= 3'b000;
    end else begin
      ack    <= next_ack;
      claim  <= next_claim;
      rdata  <= next_rdata;
      dsel   <= next_dsel;
      dwe    <= next_dwe;
      dwdata <= next_dwdata;
      rsel   <= next_rsel;
    end
  end

  assign link.io_ack   = ack;
  assign link.io_claim = claim;
  assign link.io_rdata = rdata;
  assign dock_sel      = dsel;
  assign dock_we       = dwe;
  assign dock_wdata    = dwdata;
  assign fir_sel       = rsel[0];
  assign rt_sel        = rsel[1];
  assign cir_sel       = rsel[2];
  assign active        = act;
  assign dock_base     = {base_hi, base_lo};

  // pad drivers, registered so pads never glitch on decode changes
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pad
      logic next_out;
      logic next_oe_n;
      logic pad_out;
      logic pad_oe_n;
      // open drain only pulls low; a high is left to the pull-up
      always_comb begin
        if (otype[gi]) begin
          next_out  = 1'b0;
          next_oe_n = !(gpio3_dir[gi] && !gpio3_data[gi]);
        end else begin
          next_out  = gpio3_data[gi];
          next_oe_n = !gpio3_dir[gi];
        end
      end
      always_ff @(posedge pclk or negedge sby_presetn) begin
        if (!sby_presetn) begin
          pad_out  <= 1'b0;
          pad_oe_n <= 1'b1;
        end else begin
          pad_out  <= next_out;
          pad_oe_n <= next_oe_n;
        end
      end
      assign gpio3_pin_out[gi]  = pad_out;
      assign gpio3_pin_oe_n[gi] = pad_oe_n;
    end
  endgenerate

endmodule
`default_nettype wire

//--- design/ldad_host.sv
// host end: apb slave that turns software commands into single i/o
// cycles on the link and reports the answer; assumes apb on pclk
`timescale 1ns/100ps
`default_nettype none
module ldad_host
  import ldad_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link to device
  ldad_link_if.host        link
);

  ldad_hst_e   state;
  ldad_hst_e   next_state;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [7:0]  wdata;
  logic [7:0]  next_wdata;
  logic        wr;
  logic        next_wr;
  logic        cfg;
  logic        next_cfg;
  logic [7:0]  last_rdata;
  logic [7:0]  next_last_rdata;
  logic        last_claim;
  logic        next_last_claim;
  logic [31:0] rd_q;
  logic [31:0] next_rd_q;
  logic        err_q;
  logic        next_err_q;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        busy;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == APB_CMD) || (paddr == APB_CTRL) ||
                  (paddr == APB_STAT);
  assign busy   = (state != HST_IDLE);

  // zero wait states: read data is captured in the setup cycle
  assign pready  = access;
  assign prdata  = rd_q;
  assign pslverr = access && err_q;

  // register file, command sequencer and read capture
  always_comb begin
    next_state      = state;
    next_addr       = addr;
    next_wdata      = wdata;
    next_wr         = wr;
    next_cfg        = cfg;
    next_last_rdata = last_rdata;
    next_last_claim = last_claim;
    next_rd_q       = rd_q;
    next_err_q      = err_q;
    if (setup) begin
      next_err_q = !mapped;
      case (paddr)
        APB_CMD:  next_rd_q = {7'h00, wr, wdata, addr};
        APB_CTRL: next_rd_q = {31'h0, cfg};
        APB_STAT: next_rd_q = {16'h0, last_rdata, 6'h00, last_claim, busy};
        default:  next_rd_q = 32'h0;
      endcase
    end
    case (state)
      HST_IDLE: begin
        // a command written while busy would be dropped, so only here
        if (access && pwrite && paddr == APB_CMD) begin
          next_addr  = pwdata[CMD_ADDR_LSB +: 16];
          next_wdata = pwdata[CMD_DATA_LSB +: 8];
          next_wr    = pwdata[CMD_WR_BIT];
          next_state = HST_REQ;
        end
      end
      HST_REQ:  next_state = HST_WAIT;
      HST_WAIT: begin
        if (link.io_ack) begin
          next_last_rdata = link.io_rdata;
          next_last_claim = link.io_claim;
          next_state      = HST_IDLE;
        end
      end
      default:  next_state = HST_IDLE;
    endcase
    if (access && pwrite && paddr == APB_CTRL) begin
      next_cfg = pwdata[CTRL_CFG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= HST_IDLE;
      addr       <= 16'h0000;
      wdata      <= 8'h00;
      wr         <= 1'b0;
      cfg        <= 1'b0;
      last_rdata <= 8'h00;
      last_claim <= 1'b0;
      rd_q       <= 32'h0;
      err_q      <= 1'b0;
    end else begin
      state      <= next_state;
      addr       <= next_addr;
      wdata      <= next_wdata;
      wr         <= next_wr;
      cfg        <= next_cfg;
      last_rdata <= next_last_rdata;
      last_claim <= next_last_claim;
      rd_q       <= next_rd_q;
      err_q      <= next_err_q;
    end
  end

  // link drive
  assign link.cfg_mode = cfg;
  assign link.io_req   = (state == HST_REQ);
  assign link.io_wr    = wr;
  assign link.io_addr  = addr;
  assign link.io_wdata = wdata;

endmodule
`default_nettype wire

//--- inc/ldad_link_if.sv
// link between host controller and device end: a configuration-state
// level plus a single-byte i/o cycle with a one-cycle request pulse
`timescale 1ns/100ps
`default_nettype none
interface ldad_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        cfg_mode;   // host holds device in configuration state
  logic        io_req;     // one-cycle i/o cycle request
  logic        io_wr;      // 1 write, 0 read
  logic [15:0] io_addr;    // full 16-bit i/o address
  logic [7:0]  io_wdata;   // write byte
  logic [7:0]  io_rdata;   // read byte, valid with io_ack
  logic        io_ack;     // one-cycle answer
  logic        io_claim;   // device decoded the cycle, valid with io_ack

  modport dev (
    input  cfg_mode, io_req, io_wr, io_addr, io_wdata,
    output io_rdata, io_ack, io_claim
  );
  modport host (
    output cfg_mode, io_req, io_wr, io_addr, io_wdata,
    input  io_rdata, io_ack, io_claim
  );
endinterface
`default_nettype wire

//--- inc/ldad_pkg.sv
// constants and types shared by the activate/dock decode device end and
// its host-side controller; assumes one clock and active-low resets
package ldad_pkg;

  // configuration register indices, selected through the index port
  localparam logic [7:0]  IDX_GPIO3_OTYPE = 8'h39;
  localparam logic [7:0]  IDX_ACTIVATE    = 8'h3a;
  localparam logic [7:0]  IDX_DOCK_HI     = 8'h3b;
  localparam logic [7:0]  IDX_DOCK_LO     = 8'h3c;

  // reset values
  localparam logic [7:0]  RST_GPIO3_OTYPE = 8'hff;
  localparam logic [3:0]  RST_ACTIVATE    = 4'h0;
  localparam logic [7:0]  RST_DOCK_BYTE   = 8'h00;
  localparam logic [7:0]  RST_INDEX       = 8'h00;

  // activate register bit positions
  localparam int          ACT_FIR         = 0;
  localparam int          ACT_RT          = 1;
  localparam int          ACT_CIR         = 2;
  localparam int          ACT_DOCK        = 3;
  localparam int          ACT_BITS        = 4;

  // configuration port location; data port sits one above the index port
  localparam logic [15:0] CFG_PORT_DEFAULT = 16'h002e;
  localparam logic [15:0] CFG_DATA_OFFSET  = 16'h0001;

  // value returned for an index or address nobody owns
  localparam logic [7:0]  FLOAT_DATA      = 8'hff;

  // host controller apb register offsets
  localparam logic [11:0] APB_CMD         = 12'h000;
  localparam logic [11:0] APB_CTRL        = 12'h004;
  localparam logic [11:0] APB_STAT        = 12'h008;

  // host controller field positions
  localparam int          CMD_ADDR_LSB    = 0;
  localparam int          CMD_DATA_LSB    = 16;
  localparam int          CMD_WR_BIT      = 24;
  localparam int          CTRL_CFG_BIT    = 0;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_CLAIM_BIT  = 1;
  localparam int          STAT_RDATA_LSB  = 8;

  // host controller states
  typedef enum logic [2:0] {
    HST_IDLE = 3'b001,
    HST_REQ  = 3'b010,
    HST_WAIT = 3'b100
  } ldad_hst_e;

endpackage

//--- tb/ldad_link_checker.sv
// checker on the link between host controller and device end
// assumes pclk clocks both ends and presetn resets both of them
`timescale 1ns/100ps
`default_nettype none
module ldad_link_checker
  import ldad_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link signals
  input wire logic        cfg_mode,
  input wire logic        io_req,
  input wire logic        io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_ack,
  input wire logic        io_claim
);
  logic [7:0]  idx, next_idx;
  logic [3:0]  act, next_act;
  logic [15:0] base, next_base;
  logic        ihit, dhit, dock, rd;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // port decode; the ports only open in configuration state
  assign ihit = io_req && cfg_mode && io_addr == CFG_PORT_DEFAULT;
  assign dhit = io_req && cfg_mode &&
                io_addr == CFG_PORT_DEFAULT + CFG_DATA_OFFSET;
  assign dock = io_req && !ihit && !dhit && act[3] && io_addr == base;
  assign rd   = dhit && !io_wr;

  // shadow of index, activate and base, rebuilt from seen writes
  always_comb begin
    next_idx  = idx;
    next_act  = act;
    next_base = base;
    if (ihit && io_wr) next_idx = io_wdata;
    if (dhit && io_wr && idx == IDX_ACTIVATE) next_act = io_wdata[3:0];
    if (dhit && io_wr && idx == IDX_DOCK_HI) next_base[15:8] = io_wdata;
    if (dhit && io_wr && idx == IDX_DOCK_LO) next_base[7:0] = io_wdata;
  end
  // registered at the request edge, as the device does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx  <= RST_INDEX;
      act  <= RST_ACTIVATE;
      base <= {2{RST_DOCK_BYTE}};
    end else begin
      idx  <= next_idx;
      act  <= next_act;
      base <= next_base;
    end
  end

  chk_ack_follows: assert property (io_req |=> io_ack)
    else $error("request not answered next cycle");
  chk_ack_cause: assert property (!io_req |=> !io_ack)
    else $error("answer without request");
  chk_req_spacing: assert property (io_req |=> !io_req [*2])
    else $error("requests closer than three cycles");
  chk_cfg_claim: assert property (ihit || dhit |=> io_claim)
    else $error("configuration port not claimed");
  chk_act_read: assert property (rd && idx == IDX_ACTIVATE
    |=> io_rdata == {4'h0, act})
    else $error("activate read value wrong");
  chk_base_read: assert property (rd && idx == IDX_DOCK_HI
    |=> io_rdata == base[15:8])
    else $error("dock base high byte read wrong");
  chk_dock_claim: assert property (dock |=> io_claim)
    else $error("dock access not claimed");
  chk_idle_decode: assert property (io_req && !ihit && !dhit
    && !dock && act[2:0] == 3'h0 |=> !io_claim)
    else $error("cycle claimed with no active owner");

  cover property (rd && idx == IDX_ACTIVATE);
  cover property (dock);
  cover property (io_req && !cfg_mode && io_addr == CFG_PORT_DEFAULT);
endmodule
`default_nettype wire

//--- tb/logical_device_activate_and_dock_decode_test.sv
// bench: apb master on the host end, device end joined over the link
// assumes one clock for both ends; the bench drives all side inputs
`timescale 1ns/100ps
`default_nettype none
module logical_device_activate_and_dock_decode_test
  import ldad_pkg::*;
;
  localparam logic [15:0] DP = CFG_PORT_DEFAULT + CFG_DATA_OFFSET;
  logic        pclk = 1'b0, presetn = 1'b0, sby_presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, dock_sel, dock_we, fir_sel, rt_sel, cir_sel;
  logic        fir_range_hit = 1'b0, rt_range_hit = 1'b0, cir_range_hit = 1'b0;
  logic [7:0]  dock_rdata = 8'h00, gpio3_dir = 8'h00, gpio3_data = 8'h00;
  logic [7:0]  dock_wdata, gpio3_pin_out, gpio3_pin_oe_n;
  logic [3:0]  active;
  logic [15:0] dock_base, res, sel_last = 16'h0;
  logic        sel_clr = 1'b0;
  int          err_total = 0, check_count = 0;

  ldad_link_if ldad_link_if_i (.pclk, .presetn);
  ldad_host ldad_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(ldad_link_if_i.host));
  ldad_dev ldad_dev_i (.pclk, .presetn, .sby_presetn,
    .link(ldad_link_if_i.dev), .fir_range_hit, .rt_range_hit,
    .cir_range_hit, .dock_rdata, .dock_sel, .dock_we, .dock_wdata,
    .fir_sel, .rt_sel, .cir_sel, .active, .dock_base, .gpio3_dir,
    .gpio3_data, .gpio3_pin_out, .gpio3_pin_oe_n);
  ldad_link_checker ldad_link_checker_i (.pclk, .presetn,
    .cfg_mode(ldad_link_if_i.cfg_mode), .io_req(ldad_link_if_i.io_req),
    .io_wr(ldad_link_if_i.io_wr), .io_addr(ldad_link_if_i.io_addr),
    .io_wdata(ldad_link_if_i.io_wdata), .io_rdata(ldad_link_if_i.io_rdata),
    .io_ack(ldad_link_if_i.io_ack), .io_claim(ldad_link_if_i.io_claim));

  // 250 mhz clock
  always #2 pclk = ~pclk;
  // selects are one-cycle pulses, so keep the last one seen
  // a clear request from a scenario wins, so only this block drives it
  always @(posedge pclk) begin
    if (sel_clr)
      sel_last <= 16'h0;
    else if (|{dock_sel, cir_sel, rt_sel, fir_sel})
      sel_last <= {11'h0, dock_we, dock_sel, cir_sel, rt_sel, fir_sel};
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link cycle; res gets {claim, read byte}
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, APB_CMD, {7'h0, w, d, a}, r);
    do begin
      apb(1'b0, APB_STAT, 32'h0, r);
    end while (r[STAT_BUSY_BIT] !== 1'b0);
    res = {7'h0, r[STAT_CLAIM_BIT], r[STAT_RDATA_LSB +: 8]};
  endtask
  // forget earlier select pulses before a cycle whose pulses are judged
  task automatic sel_reset;
    sel_clr <= 1'b1;
    @(posedge pclk);
    sel_clr <= 1'b0;
  endtask
  task automatic cfgw(input logic [7:0] i, d);
    io(1'b1, CFG_PORT_DEFAULT, i);
    io(1'b1, DP, d);
  endtask
  task automatic cfgr(input logic [7:0] i);
    io(1'b1, CFG_PORT_DEFAULT, i);
    io(1'b0, DP, 8'h00);
  endtask

  task automatic t_reset;
    cfgr(IDX_ACTIVATE);
    chk("act", {8'h01, 4'h0, RST_ACTIVATE}, res);
    cfgr(IDX_DOCK_HI);
    chk("dock hi", {8'h01, RST_DOCK_BYTE}, res);
    cfgr(IDX_DOCK_LO);
    chk("dock lo", {8'h01, RST_DOCK_BYTE}, res);
    cfgr(IDX_GPIO3_OTYPE);
    chk("otype", {8'h01, RST_GPIO3_OTYPE}, res);
  endtask
  // ports shut outside configuration state; unmapped apb word
  task automatic t_refuse;
    apb(1'b1, APB_CTRL, 32'h0, r);
    io(1'b1, CFG_PORT_DEFAULT, IDX_ACTIVATE);
    chk("idx off", 16'h00ff, res);
    io(1'b1, DP, 8'h0f);
    chk("data off", 16'h00ff, res);
    apb(1'b1, APB_CTRL, 32'h1, r);
    apb(1'b0, APB_CTRL, 32'h0, r);
    chk("ctrl rd", 16'h1, r[15:0]);
    chk("active", 16'h0, {12'h0, active});
    apb(1'b1, 12'h00c, 32'h1, r);
    chk("slverr", 16'h1, {15'h0, slv});
  endtask
  // each activate bit alone, every range hit raised
  task automatic t_activate;
    logic [3:0] e;
    cfgw(IDX_ACTIVATE, 8'hff);
    cfgr(IDX_ACTIVATE);
    chk("act rsvd", 16'h010f, res);
    {fir_range_hit, rt_range_hit, cir_range_hit} <= 3'b111;
    for (int i = 0; i < 5; i++) begin
      e = 4'h1 << i;
      cfgw(IDX_ACTIVATE, {4'h0, e});
      sel_reset;
      io(1'b0, 16'h0300, 8'h00);
      chk("rt claim", {7'h0, |e[2:0], 8'hff}, res);
      chk("rt sel", {13'h0, e[2:0]}, sel_last);
    end
    {fir_range_hit, rt_range_hit, cir_range_hit} <= 3'b000;
  endtask
  task automatic t_dock;
    cfgw(IDX_DOCK_HI, 8'ha5);
    cfgw(IDX_DOCK_LO, 8'h5a);
    cfgr(IDX_DOCK_LO);
    chk("dock lo", 16'h015a, res);
    cfgw(IDX_ACTIVATE, 8'h08);
    chk("base", 16'ha55a, dock_base);
    dock_rdata <= 8'h3c;
    sel_reset;
    io(1'b0, 16'ha55a, 8'h00);
    chk("dock rd", 16'h013c, res);
    chk("dock sel", 16'h0008, sel_last);
    sel_reset;
    io(1'b1, 16'ha55a, 8'h77);
    chk("dock wr", 16'h0077, {8'h0, dock_wdata});
    chk("dock we", 16'h0018, sel_last);
    apb(1'b0, APB_CMD, 32'h0, r);
    chk("cmd lo", 16'ha55a, r[15:0]);
    chk("cmd hi", 16'h0177, r[31:16]);
    for (int b = 0; b < 16; b++) begin
      io(1'b0, 16'ha55a ^ (16'h1 << b), 8'h00);
      chk("near", 16'h00ff, res);
    end
    cfgw(IDX_ACTIVATE, 8'h00);
    cfgw(IDX_DOCK_HI, 8'hff);
    cfgw(IDX_DOCK_LO, 8'hff);
    io(1'b0, 16'hffff, 8'h00);
    chk("dock off", 16'h00ff, res);
    cfgw(IDX_ACTIVATE, 8'h08);
    io(1'b0, 16'hffff, 8'h00);
    chk("dock top", 16'h013c, res);
  endtask
  // low nibble open-drain, then each reset on its own
  task automatic t_gpio;
    gpio3_dir <= 8'hff;
    gpio3_data <= 8'h55;
    cfgw(IDX_GPIO3_OTYPE, 8'h0f);
    repeat (2) @(posedge pclk);
    chk("pads", {8'h55 & 8'hf0, 8'h55 & 8'h0f},
        {gpio3_pin_out, gpio3_pin_oe_n});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, APB_CTRL, 32'h1, r);
    chk("active", 16'h0, {12'h0, active});
    chk("base rst", {2{RST_DOCK_BYTE}}, dock_base);
    cfgr(IDX_GPIO3_OTYPE);
    chk("otype", 16'h010f, res);
    sby_presetn <= 1'b0;
    @(posedge pclk);
    sby_presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pads od", 16'h0055, {gpio3_pin_out, gpio3_pin_oe_n});
    cfgr(IDX_GPIO3_OTYPE);
    chk("otype sby", {8'h01, RST_GPIO3_OTYPE}, res);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    sby_presetn <= 1'b1;
    apb(1'b1, APB_CTRL, 32'h1, r);
    t_reset;
    t_refuse;
    t_activate;
    t_dock;
    t_gpio;
    end_of_test;
  end
  // cut a hang short well past the expected run of roughly seven hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
